// >>> src/lprc_pkg.sv
// constants for the low power reset control block
`default_nettype none
package lprc_pkg;
  localparam int unsigned RESET_MIN_OSC_PERIODS = 24;
  localparam int unsigned RESET_CNT_W           = 5;
  localparam logic [1:0]  PWR_CTL_IDLE_BIT      = 2'h0;
  localparam logic [1:0]  PWR_CTL_PD_BIT        = 2'h1;
  localparam int unsigned PWR_CTL_W             = 8;
  localparam int unsigned PORT_W                = 8;
  typedef enum logic [1:0] {
    LPRC_RUN   = 2'h0,
    LPRC_IDLE  = 2'h1,
    LPRC_PDOWN = 2'h2
  } lprc_mode_t;
endpackage
`default_nettype wire

// >>> src/lprc_reset_detect.sv
// reset pin synchroniser and high-level length detector
`default_nettype none
module lprc_reset_detect #(
  parameter int unsigned MIN_PERIODS = lprc_pkg::RESET_MIN_OSC_PERIODS
) (
  input  wire logic clk_in,        // oscillator clock
  input  wire logic rst_pin_in,    // raw reset pin
  output logic      reset_out      // internal reset level
);
  // power-up values: nothing can reset the block that makes the reset
  logic s1_q = 1'b0;
  logic s2_q = 1'b0;
  logic s3_q = 1'b0;
  logic [lprc_pkg::RESET_CNT_W-1:0] cnt_q = '0;
  logic [lprc_pkg::RESET_CNT_W-1:0] cnt_d;
  wire  high_agreed;
  wire  at_min;

  assign high_agreed = s2_q & s3_q;
  assign at_min      = (cnt_q >= lprc_pkg::RESET_CNT_W'(MIN_PERIODS));
  assign cnt_d       = !high_agreed ? '0 : (at_min ? cnt_q : cnt_q + 1'b1);

  // no reset here: this block makes the reset
  always_ff @(posedge clk_in) begin
    s1_q  <= rst_pin_in;
    s2_q  <= s1_q;
    s3_q  <= s2_q;
    cnt_q <= cnt_d;
  end

  assign reset_out = at_min & high_agreed;

  property p_reset_after_min;
    @(posedge clk_in) (high_agreed && cnt_q == lprc_pkg::RESET_CNT_W'(MIN_PERIODS - 1)) ##1 high_agreed
      |-> reset_out;
  endproperty
  a_reset_after_min: assert property (p_reset_after_min) else $error("reset not raised after count");

  property p_low_clears;
    @(posedge clk_in) !high_agreed |=> (cnt_q == '0) && !reset_out;
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("count not cleared on low pin");
endmodule
`default_nettype wire

// >>> src/lprc_top.sv
// low power reset control: reset detect, idle and power-down sequencing
// Summary of operation
// - Reset pin high for 24 oscillator periods with oscillator running resets the device.
// - Internal clock comes from a divide-by-two flip-flop, duty cycle irrelevant.
// - Idle request instruction is the last completed before idle takes effect.
// - Idle halts the processor; processor state, RAM and registers stay unchanged.
// - Any enabled interrupt ends idle; service routine runs, then program continues.
// - Hardware reset ends idle and restarts like power-on reset.
// - Power-down completes the requesting instruction, then stops the oscillator.
// - Only RAM contents are guaranteed retained in power-down.
// - Only hardware reset ends power-down; interrupts do not.
// - Idle and power-down requests come from power control register bits.
// - Idle: strobes high, pulse outputs high; port 0 floats with external memory.
// - Power-down: strobes low, pulse outputs high; port 0 floats with external memory.
`default_nettype none
module lprc_top #(
  parameter int unsigned RESET_PERIODS = lprc_pkg::RESET_MIN_OSC_PERIODS
) (
  input  wire logic                          clk_in,                   // oscillator input pin clock
  input  wire logic                          rst_in,                   // reset pin level
  input  wire logic [lprc_pkg::PWR_CTL_W-1:0] power_control_register_in,// power control register contents
  input  wire logic                          instr_done_in,            // core completes an instruction
  input  wire logic                          int_pending_in,           // an enabled interrupt is pending
  input  wire logic                          ext_prog_mem_in,          // program runs from external memory
  input  wire logic                          core_ale_in,              // core address latch strobe
  input  wire logic                          core_fetch_in,            // core program fetch strobe
  input  wire logic                          core_pulse0_in,           // core pulse output zero
  input  wire logic                          core_pulse1_in,           // core pulse output one
  input  wire logic [lprc_pkg::PORT_W-1:0]   core_p2_in,               // core port 2 drive value
  input  wire logic [lprc_pkg::PORT_W-1:0]   addr_hi_in,               // high address byte
  output logic                               sys_reset_out,            // internal reset
  output logic                               clk_en_out,               // divide-by-two clock enable
  output logic                               core_run_out,             // core may advance
  output logic                               periph_run_out,           // peripherals may advance
  output logic                               osc_stop_out,             // oscillator stopped
  output logic                               idle_clear_out,           // clear idle bit pulse
  output logic                               address_latch_strobe_out, // address latch strobe pin
  output logic                               program_fetch_strobe_out, // program fetch strobe pin
  output logic                               pulse_output_zero_out,    // pulse output zero pin
  output logic                               pulse_output_one_out,     // pulse output one pin
  output logic                               port0_oe_out,             // port 0 drive enable
  output logic                               port2_addr_sel_out,       // port 2 carries address
  output logic [lprc_pkg::PORT_W-1:0]        port2_out                 // port 2 value
);
  ////////////////////////////////////////////////////////////////////////////
  lprc_pkg::lprc_mode_t mode_q;
  lprc_pkg::lprc_mode_t mode_d;
  logic div_q;
  logic [lprc_pkg::PORT_W-1:0] p2_q;
  wire  rst_int;
  wire  idle_req;
  wire  pd_req;
  wire  in_idle;
  wire  in_pd;

  lprc_reset_detect #(
    .MIN_PERIODS (RESET_PERIODS)
  ) u_det (
    .clk_in     (clk_in),
    .rst_pin_in (rst_in),
    .reset_out  (rst_int)
  );

  assign idle_req = power_control_register_in[lprc_pkg::PWR_CTL_IDLE_BIT];
  assign pd_req   = power_control_register_in[lprc_pkg::PWR_CTL_PD_BIT];
  assign in_idle  = (mode_q == lprc_pkg::LPRC_IDLE);
  assign in_pd    = (mode_q == lprc_pkg::LPRC_PDOWN);

  ////////////////////////////////////////////////////////////////////////////
  // divide by two; frozen while the oscillator is stopped
  always_ff @(posedge clk_in) begin
    if (rst_in | rst_int) begin
      div_q <= 1'b0;
    end else if (!in_pd) begin
      div_q <= ~div_q;
    end
  end
  assign clk_en_out = div_q & !in_pd;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      lprc_pkg::LPRC_RUN: begin
        if (clk_en_out && instr_done_in && pd_req) begin
          mode_d = lprc_pkg::LPRC_PDOWN;
        end else if (clk_en_out && instr_done_in && idle_req) begin
          mode_d = lprc_pkg::LPRC_IDLE;
        end
      end
      lprc_pkg::LPRC_IDLE: begin
        if (int_pending_in) begin
          mode_d = lprc_pkg::LPRC_RUN;
        end
      end
      lprc_pkg::LPRC_PDOWN: begin
        mode_d = lprc_pkg::LPRC_PDOWN;
      end
      default: begin
        mode_d = lprc_pkg::LPRC_RUN;
      end
    endcase
  end

  // reset releases idle and power-down alike
  always_ff @(posedge clk_in) begin
    if (rst_in | rst_int) begin
      mode_q <= lprc_pkg::LPRC_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign sys_reset_out  = rst_int;
  assign core_run_out   = clk_en_out & !in_idle;
  assign periph_run_out = clk_en_out;
  assign osc_stop_out   = in_pd;
  assign idle_clear_out = in_idle & int_pending_in;

  ////////////////////////////////////////////////////////////////////////////
  // pin states; port 2 keeps the address on idle entry with external memory, else the data; the data on power-down entry
  always_ff @(posedge clk_in) begin
    if (rst_in | rst_int) begin
      p2_q <= '0;
    end else if (!in_idle && !in_pd) begin
      p2_q <= (ext_prog_mem_in & !pd_req) ? addr_hi_in : core_p2_in;
    end
  end

  assign address_latch_strobe_out = in_idle ? 1'b1 : (in_pd ? 1'b0 : core_ale_in);
  assign program_fetch_strobe_out = in_idle ? 1'b1 : (in_pd ? 1'b0 : core_fetch_in);
  assign pulse_output_zero_out    = (in_idle | in_pd) ? 1'b1 : core_pulse0_in;
  assign pulse_output_one_out     = (in_idle | in_pd) ? 1'b1 : core_pulse1_in;
  assign port0_oe_out             = !((in_idle | in_pd) & ext_prog_mem_in);
  assign port2_addr_sel_out       = ext_prog_mem_in & !in_pd;
  assign port2_out                = p2_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_pd_sticky;
    @(posedge clk_in) disable iff (rst_in | rst_int) in_pd |=> in_pd;
  endproperty
  a_pd_sticky: assert property (p_pd_sticky) else $error("power-down left without reset");

  property p_idle_entry;
    @(posedge clk_in) disable iff (rst_in | rst_int)
      (mode_q == lprc_pkg::LPRC_RUN && clk_en_out && instr_done_in && idle_req && !pd_req) |=> in_idle;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_idle_exit;
    @(posedge clk_in) disable iff (rst_in | rst_int) (in_idle && int_pending_in) |=> !in_idle;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");

  property p_idle_pins;
    @(posedge clk_in) in_idle |-> address_latch_strobe_out && program_fetch_strobe_out
      && pulse_output_zero_out && pulse_output_one_out && !core_run_out;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle pin state wrong");

  property p_pd_pins;
    @(posedge clk_in) in_pd |-> !address_latch_strobe_out && !program_fetch_strobe_out
      && pulse_output_zero_out && pulse_output_one_out && osc_stop_out && !clk_en_out;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("power-down pin state wrong");

  property p_reset_exits;
    @(posedge clk_in) rst_int |=> (mode_q == lprc_pkg::LPRC_RUN);
  endproperty
  a_reset_exits: assert property (p_reset_exits) else $error("reset did not restart");

  property p_div;
    @(posedge clk_in) disable iff (rst_in | rst_int) (clk_en_out && !in_pd) |=> !clk_en_out;
  endproperty
  a_div: assert property (p_div) else $error("clock enable not halved");

  property p_port2_hold;
    @(posedge clk_in) disable iff (rst_in | rst_int) (in_idle && $past(in_idle)) |-> $stable(port2_out);
  endproperty
  a_port2_hold: assert property (p_port2_hold) else $error("port 2 changed in idle");

  ////////////////////////////////////////////////////////////////////////////
  property p_pd_entry;
    @(posedge clk_in) disable iff (rst_in | rst_int)
      (mode_q == lprc_pkg::LPRC_RUN && clk_en_out && instr_done_in && pd_req) |=> in_pd;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_entry_on_retire;
    @(posedge clk_in) disable iff (rst_in | rst_int)
      (mode_q == lprc_pkg::LPRC_RUN && !(clk_en_out && instr_done_in)) |=> (mode_q == lprc_pkg::LPRC_RUN);
  endproperty
  a_entry_on_retire: assert property (p_entry_on_retire) else $error("mode left before instruction end");

  property p_idle_stay;
    @(posedge clk_in) disable iff (rst_in | rst_int) (in_idle && !int_pending_in) |=> in_idle;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("idle left without interrupt");

  property p_port0_float;
    @(posedge clk_in) ((in_idle || in_pd) && ext_prog_mem_in) |-> !port0_oe_out;
  endproperty
  a_port0_float: assert property (p_port0_float) else $error("port 0 driven in low power");

  property p_port0_drive;
    @(posedge clk_in) !ext_prog_mem_in |-> port0_oe_out;
  endproperty
  a_port0_drive: assert property (p_port0_drive) else $error("port 0 released with internal memory");

  property p_port2_addr_idle;
    @(posedge clk_in) (in_idle && ext_prog_mem_in) |-> port2_addr_sel_out;
  endproperty
  a_port2_addr_idle: assert property (p_port2_addr_idle) else $error("port 2 not on address in idle");

  property p_port2_data_pd;
    @(posedge clk_in) in_pd |-> !port2_addr_sel_out;
  endproperty
  a_port2_data_pd: assert property (p_port2_data_pd) else $error("port 2 on address in power-down");

  property p_pd_port2_hold;
    @(posedge clk_in) disable iff (rst_in | rst_int) (in_pd && $past(in_pd)) |-> $stable(port2_out);
  endproperty
  a_pd_port2_hold: assert property (p_pd_port2_hold) else $error("port 2 changed in power-down");

  property p_periph_idle;
    @(posedge clk_in) (in_idle && clk_en_out) |-> periph_run_out;
  endproperty
  a_periph_idle: assert property (p_periph_idle) else $error("peripherals stopped in idle");
endmodule
`default_nettype wire

// >>> verif/lprc_core_model.sv
// core model: retires instructions, toggles its strobes and holds interrupts
`default_nettype none
module lprc_core_model (
  input  wire logic clk_in,     // oscillator clock
  input  wire logic rst_in,     // reset pin level
  input  wire logic run_in,     // core may advance
  input  wire logic en_in,      // clock enable
  input  wire logic int_req_in, // bench raises an interrupt
  input  wire logic clr_in,     // idle exit takes the interrupt
  output logic      done_out,   // instruction retired
  output logic      pend_out,   // interrupt pending
  output logic      ale_out,    // core address strobe
  output logic      fetch_out   // core fetch strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  assign done_out = run_in & en_in;
  initial begin
    pend_out = 1'b0;
    ale_out = 1'b0;
    fetch_out = 1'b1;
  end
  // strobes run in opposite phase so forced levels are visible
  always @(posedge clk_in) begin
    ale_out <= ~ale_out;
    fetch_out <= ale_out;
    if (clr_in | rst_in) begin
      pend_out <= 1'b0;
    end else if (int_req_in) begin
      pend_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/lprc_top_tb.sv
// self-checking bench for the low power reset control block
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
`define WAIT_FOR(c) begin n = 0; while (!(c) && n < 40) begin @(posedge clk); n++; end end
module lprc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, ext = 0, ireq = 0, take = 0, ok;
  logic [7:0]  pwr_ctl = 8'h00, data = 8'h00, addr = 8'h00, p2;
  logic        done, pend, ale_c, fetch_c, sys_rst, clk_en, core_run, prun, osc, iclr, ale, fetch, pz, po, oe, sel;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  int          bad_count = 0, num_checks = 0, cyc = 0, n;
  wire [15:0]  obs = {sys_rst, osc, ale, fetch, pz, po, oe, sel, p2};
  lprc_top #(.RESET_PERIODS(4)) dut_u (.clk_in(clk), .rst_in(rst), .power_control_register_in(pwr_ctl),
    .instr_done_in(done), .int_pending_in(pend), .ext_prog_mem_in(ext), .core_ale_in(ale_c),
    .core_fetch_in(fetch_c), .core_pulse0_in(1'b0), .core_pulse1_in(1'b0), .core_p2_in(data),
    .addr_hi_in(addr), .sys_reset_out(sys_rst), .clk_en_out(clk_en), .core_run_out(core_run),
    .periph_run_out(prun), .osc_stop_out(osc), .idle_clear_out(iclr), .address_latch_strobe_out(ale),
    .program_fetch_strobe_out(fetch), .pulse_output_zero_out(pz), .pulse_output_one_out(po),
    .port0_oe_out(oe), .port2_addr_sel_out(sel), .port2_out(p2));
  lprc_core_model core_u (.clk_in(clk), .rst_in(rst), .run_in(core_run), .en_in(clk_en), .int_req_in(ireq),
    .clr_in(iclr), .done_out(done), .pend_out(pend), .ale_out(ale_c), .fetch_out(fetch_c));
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic expect_v(input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v});
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pin_reset(input int k);
    rst <= 1'b1;
    tick(k);
    rst <= 1'b0;
    tick(1);
  endtask
  // pin levels forced in idle (pd=0) or power-down (pd=1)
  function automatic logic [15:0] mode_v(input logic pd, input logic x);
    return {1'b0, pd, ~pd, ~pd, 1'b1, 1'b1, ~x, x & ~pd, (x & ~pd) ? addr : data};
  endfunction
  ////////////////////////////////////////
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  always @(posedge clk) begin
    if (take) begin
      e = exp_q.pop_front();
      `CHK(obs & e[31:16], e[15:0])
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h00a8));
    tick(6);
    rst <= 1'b0;
    tick(2);
    pin_reset(3);
    pin_reset(3);
    tick(8);
    expect_v(16'h8000, 16'h0000);
    rst <= 1'b1;
    tick(16);
    expect_v(16'h8000, 16'h8000);
    rst <= 1'b0;
    `WAIT_FOR(!sys_rst)
    `CHK(n < 40, 1'b1)
    ok = clk_en;
    tick(1);
    `CHK(clk_en, ~ok)
    for (int x = 0; x < 2; x++) begin
      ext <= x[0];
      data <= 8'($urandom);
      addr <= 8'($urandom);
      pwr_ctl <= 8'h01;
      `WAIT_FOR(ale & fetch)
      pwr_ctl <= 8'h00;
      `CHK(n < 40, 1'b1)
      tick(2);
      expect_v(16'hffff, mode_v(1'b0, x[0]));
      ok = 1'b0;
      repeat (8) begin
        @(posedge clk);
        ok = ok | prun;
        `CHK(core_run, 1'b0)
      end
      `CHK(ok, 1'b1)
      ireq <= 1'b1;
      `WAIT_FOR(iclr)
      ireq <= 1'b0;
      `CHK(n < 40, 1'b1)
      `WAIT_FOR(ale != fetch)
      `CHK(n < 40, 1'b1)
      pwr_ctl <= x[0] ? 8'h03 : 8'h02;
      `WAIT_FOR(osc)
      pwr_ctl <= 8'h00;
      `CHK(n < 40, 1'b1)
      tick(2);
      expect_v(16'hffff, mode_v(1'b1, x[0]));
      ireq <= 1'b1;
      tick(10);
      ireq <= 1'b0;
      expect_v(16'h4000, 16'h4000);
      pin_reset(16);
      expect_v(16'h4000, 16'h0000);
      `WAIT_FOR(!sys_rst)
    end
    pwr_ctl <= 8'h01;
    `WAIT_FOR(ale & fetch)
    pwr_ctl <= 8'h00;
    `CHK(n < 40, 1'b1)
    pin_reset(16);
    `WAIT_FOR(ale != fetch)
    `CHK(n < 40, 1'b1)
    `WAIT_FOR(core_run)
    `CHK(n < 40, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
